// *** design/spm_pkg.sv ***
// ----------------------------------------------------------------------------
// Shared constants and types of the six-bit port
// ----------------------------------------------------------------------------
package spm_pkg;

  // ----------------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------------
  localparam int unsigned PIN_N  = 6;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned IDX_W  = ADDR_W - 2;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = DATA_W / 8;
  localparam int unsigned FSEL_W = 3;

  // ----------------------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PORT_DATA   = 18'h0ffd6;
  localparam logic [IDX_W-1:0] IDX_PORT_DIR    = 18'h0ffe6;
  localparam logic [IDX_W-1:0] IDX_PORT_PULLUP = 18'h0ffee;
  localparam logic [IDX_W-1:0] IDX_FUNC_SEL    = 18'h0fffd;
  localparam logic [IDX_W-1:0] IDX_TX_DRIVE    = 18'h0ffff;

  // ----------------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------------
  localparam logic [PIN_N-1:0]  RST_PORT_DATA   = 6'h00;
  localparam logic [PIN_N-1:0]  RST_PORT_DIR    = 6'h00;
  localparam logic [PIN_N-1:0]  RST_PORT_PULLUP = 6'h00;
  localparam logic [FSEL_W-1:0] RST_FUNC_SEL    = 3'h0;
  localparam logic              RST_TX_SEL      = 1'b0;
  localparam logic              RST_OD_SEL      = 1'b0;

  // ----------------------------------------------------------------------------
  // Field positions and fixed read values
  // ----------------------------------------------------------------------------
  localparam int unsigned FS_SCK_BIT = 0;   // serial_clock_select, pin 0
  localparam int unsigned FS_SI_BIT  = 1;   // serial_in_select, pin 1
  localparam int unsigned FS_SO_BIT  = 2;   // serial_out_select, pin 2
  localparam int unsigned TD_OD_BIT  = 0;   // open_drain_select
  localparam int unsigned TD_TX_BIT  = 2;   // transmit route to neighbour pin
  localparam int unsigned PIN_SCK    = 0;
  localparam int unsigned PIN_SI     = 1;
  localparam int unsigned PIN_SO     = 2;
  localparam logic [7:0]  DIR_READ_VAL  = 8'hff;
  localparam logic [7:0]  TD_FIXED_ONES = 8'hf8;

  // ----------------------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef enum logic {
    WR_COLLECT,
    WR_RESP
  } spm_wr_state_t;

  // Drive of the six pins
  typedef struct packed {
    logic [PIN_N-1:0] o;
    logic [PIN_N-1:0] oe;
    logic [PIN_N-1:0] pu;
  } spm_pin_drive_t;

  // Serial unit side of the pin mux
  typedef struct packed {
    logic so_data;
    logic sck_out;
    logic sck_oe;
  } spm_ser_from_t;

endpackage : spm_pkg

// *** design/spm_pin_sync.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------------------
module spm_pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } spm_sync_state_t;

  spm_sync_state_t q;
  spm_sync_state_t d;

  // Stage one feeds stage two only; the filter looks at two and three
  always_comb begin
    d     = q;
    d.s1  = din;
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.val = (q.s2 & q.s3) | (q.val & (q.s2 ^ q.s3));
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.val;

endmodule : spm_pin_sync

// *** design/spm_port.sv ***
`timescale 1ns/1ps
module spm_port (
  input  wire logic                                  REF_CLK,
  input  wire logic                                  RST,
  // AXI4-Lite slave
  input  wire logic [spm_pkg::ADDR_W-1:0]            S_AXI_AWADDR,
  input  wire logic                                  S_AXI_AWVALID,
  output logic                                       S_AXI_AWREADY,
  input  wire logic [spm_pkg::DATA_W-1:0]            S_AXI_WDATA,
  input  wire logic [spm_pkg::STRB_W-1:0]            S_AXI_WSTRB,
  input  wire logic                                  S_AXI_WVALID,
  output logic                                       S_AXI_WREADY,
  output logic [1:0]                                 S_AXI_BRESP,
  output logic                                       S_AXI_BVALID,
  input  wire logic                                  S_AXI_BREADY,
  input  wire logic [spm_pkg::ADDR_W-1:0]            S_AXI_ARADDR,
  input  wire logic                                  S_AXI_ARVALID,
  output logic                                       S_AXI_ARREADY,
  output logic [spm_pkg::DATA_W-1:0]                 S_AXI_RDATA,
  output logic [1:0]                                 S_AXI_RRESP,
  output logic                                       S_AXI_RVALID,
  input  wire logic                                  S_AXI_RREADY,
  // Pins
  input  wire logic [spm_pkg::PIN_N-1:0]             PIN_I,
  output spm_pkg::spm_pin_drive_t                    PIN_DRIVE,
  // Serial unit
  input  wire spm_pkg::spm_ser_from_t                SER_FROM,
  output logic                                       SER_SI_DATA,
  output logic                                       SER_SCK_IN,
  output logic [spm_pkg::FSEL_W-1:0]                 SER_PIN_OWNED,
  // Neighbouring port transmit route
  output logic                                       TX_ROUTE_SEL
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    spm_pkg::spm_wr_state_t          wr_st;
    logic                            aw_have;
    logic                            w_have;
    logic [spm_pkg::ADDR_W-1:0]      aw_addr;
    logic [spm_pkg::DATA_W-1:0]      w_data;
    logic [spm_pkg::STRB_W-1:0]      w_strb;
    logic [1:0]                      b_resp;
    logic                            r_valid;
    logic [spm_pkg::DATA_W-1:0]      r_data;
    logic [1:0]                      r_resp;
    logic [spm_pkg::PIN_N-1:0]       data;
    logic [spm_pkg::PIN_N-1:0]       dir;
    logic [spm_pkg::PIN_N-1:0]       pu;
    logic [spm_pkg::FSEL_W-1:0]      fsel;
    logic                            tx_sel;
    logic                            od_sel;
    spm_pkg::spm_pin_drive_t         drive;
  } spm_state_t;

  spm_state_t                  q;
  spm_state_t                  d;
  logic [spm_pkg::PIN_N-1:0]   pin_live;

  // ----------------------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------------------
  spm_pin_sync #(
    .W (spm_pkg::PIN_N)
  ) u_pin_sync (
    .clk  (REF_CLK),
    .rst  (RST),
    .din  (PIN_I),
    .dout (pin_live)
  );

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // Register index match for a byte address
  function automatic logic idx_hit(input logic [spm_pkg::ADDR_W-1:0] a,
                                   input logic [spm_pkg::IDX_W-1:0]  idx);
    idx_hit = (a[spm_pkg::ADDR_W-1:2] == idx);
  endfunction : idx_hit

  // Any mapped register
  function automatic logic mapped(input logic [spm_pkg::ADDR_W-1:0] a);
    mapped = idx_hit(a, spm_pkg::IDX_PORT_DATA)   | idx_hit(a, spm_pkg::IDX_PORT_DIR) |
             idx_hit(a, spm_pkg::IDX_PORT_PULLUP) | idx_hit(a, spm_pkg::IDX_FUNC_SEL) |
             idx_hit(a, spm_pkg::IDX_TX_DRIVE);
  endfunction : mapped

  // Read value of a register; unmapped reads as zero
  function automatic logic [7:0] read_val(input spm_state_t                s,
                                          input logic [spm_pkg::PIN_N-1:0] live,
                                          input logic [spm_pkg::ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (idx_hit(a, spm_pkg::IDX_PORT_DATA)) begin
      // Outputs show the latch, inputs the pin
      v = {2'h0, (s.dir & s.data) | (~s.dir & live)};
    end else if (idx_hit(a, spm_pkg::IDX_PORT_DIR)) begin
      v = spm_pkg::DIR_READ_VAL;
    end else if (idx_hit(a, spm_pkg::IDX_PORT_PULLUP)) begin
      v = {2'h0, s.pu};
    end else if (idx_hit(a, spm_pkg::IDX_FUNC_SEL)) begin
      v = {5'h00, s.fsel};
    end else if (idx_hit(a, spm_pkg::IDX_TX_DRIVE)) begin
      v = spm_pkg::TD_FIXED_ONES;
      v[spm_pkg::TD_TX_BIT] = s.tx_sel;
      v[spm_pkg::TD_OD_BIT] = s.od_sel;
    end
    read_val = v;
  endfunction : read_val

  // ----------------------------------------------------------------------------
  // Bus handshake outputs
  // ----------------------------------------------------------------------------
  // Ready only while the matching holding slot is empty
  assign S_AXI_AWREADY = (q.wr_st == spm_pkg::WR_COLLECT) & ~q.aw_have;
  assign S_AXI_WREADY  = (q.wr_st == spm_pkg::WR_COLLECT) & ~q.w_have;
  assign S_AXI_BVALID  = (q.wr_st == spm_pkg::WR_RESP);
  assign S_AXI_BRESP   = q.b_resp;
  assign S_AXI_ARREADY = ~q.r_valid;
  assign S_AXI_RVALID  = q.r_valid;
  assign S_AXI_RDATA   = q.r_data;
  assign S_AXI_RRESP   = q.r_resp;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    d = q;

    // Write channel: address and data may come in either order
    case (q.wr_st)
      spm_pkg::WR_COLLECT: begin
        if (S_AXI_AWVALID && !q.aw_have) begin
          d.aw_have = 1'b1;
          d.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !q.w_have) begin
          d.w_have = 1'b1;
          d.w_data = S_AXI_WDATA;
          d.w_strb = S_AXI_WSTRB;
        end
        if (q.aw_have && q.w_have) begin
          d.wr_st  = spm_pkg::WR_RESP;
          d.b_resp = mapped(q.aw_addr) ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
          // Registers live in byte lane 0; other lanes are dropped
          if (q.w_strb[0]) begin
            if (idx_hit(q.aw_addr, spm_pkg::IDX_PORT_DATA)) begin
              d.data = q.w_data[spm_pkg::PIN_N-1:0];
            end
            if (idx_hit(q.aw_addr, spm_pkg::IDX_PORT_DIR)) begin
              d.dir = q.w_data[spm_pkg::PIN_N-1:0];
            end
            if (idx_hit(q.aw_addr, spm_pkg::IDX_PORT_PULLUP)) begin
              d.pu = q.w_data[spm_pkg::PIN_N-1:0];
            end
            if (idx_hit(q.aw_addr, spm_pkg::IDX_FUNC_SEL)) begin
              d.fsel = q.w_data[spm_pkg::FSEL_W-1:0];
            end
            if (idx_hit(q.aw_addr, spm_pkg::IDX_TX_DRIVE)) begin
              // Only the two live bits take writes
              d.tx_sel = q.w_data[spm_pkg::TD_TX_BIT];
              d.od_sel = q.w_data[spm_pkg::TD_OD_BIT];
            end
          end
        end
      end
      spm_pkg::WR_RESP: begin
        if (S_AXI_BREADY) begin
          d.wr_st   = spm_pkg::WR_COLLECT;
          d.aw_have = 1'b0;
          d.w_have  = 1'b0;
        end
      end
      default: begin
        d.wr_st = spm_pkg::WR_COLLECT;
      end
    endcase

    // Read channel: one read at a time, data sampled at acceptance
    if (q.r_valid) begin
      if (S_AXI_RREADY) begin
        d.r_valid = 1'b0;
      end
    end else if (S_AXI_ARVALID) begin
      d.r_valid = 1'b1;
      d.r_data  = {24'h000000, read_val(q, pin_live, S_AXI_ARADDR)};
      d.r_resp  = mapped(S_AXI_ARADDR) ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
    end

    // General I/O drive for every pin; upper pins stay here always
    d.drive.o  = q.data;
    d.drive.oe = q.dir;

    // Pull-up only on inputs with the enable set
    d.drive.pu = ~q.dir & q.pu;

    // Serial clock takes pin 0 in both directions
    if (q.fsel[spm_pkg::FS_SCK_BIT]) begin
      d.drive.o[spm_pkg::PIN_SCK]  = SER_FROM.sck_out;
      d.drive.oe[spm_pkg::PIN_SCK] = SER_FROM.sck_oe;
    end

    // Serial input: pin 1 never driven
    if (q.fsel[spm_pkg::FS_SI_BIT]) begin
      d.drive.o[spm_pkg::PIN_SI]  = 1'b0;
      d.drive.oe[spm_pkg::PIN_SI] = 1'b0;
    end

    // Serial output: pin 2 driven whatever the direction, except a high bit when open drain is set
    if (q.fsel[spm_pkg::FS_SO_BIT]) begin
      d.drive.o[spm_pkg::PIN_SO]  = SER_FROM.so_data;
      d.drive.oe[spm_pkg::PIN_SO] = 1'b1;
    end

    // Open drain: no high drive, only pull low
    if (q.od_sel) begin
      d.drive.oe[spm_pkg::PIN_SO] = d.drive.oe[spm_pkg::PIN_SO] & ~d.drive.o[spm_pkg::PIN_SO];
      d.drive.o[spm_pkg::PIN_SO]  = 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      q        <= '0;
      q.data   <= spm_pkg::RST_PORT_DATA;
      q.dir    <= spm_pkg::RST_PORT_DIR;
      q.pu     <= spm_pkg::RST_PORT_PULLUP;
      q.fsel   <= spm_pkg::RST_FUNC_SEL;
      q.tx_sel <= spm_pkg::RST_TX_SEL;
      q.od_sel <= spm_pkg::RST_OD_SEL;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs to pins, serial unit and neighbour port
  // ----------------------------------------------------------------------------
  assign PIN_DRIVE     = q.drive;
  assign SER_SI_DATA   = pin_live[spm_pkg::PIN_SI];
  assign SER_SCK_IN    = pin_live[spm_pkg::PIN_SCK];
  assign SER_PIN_OWNED = q.fsel;
  assign TX_ROUTE_SEL  = q.tx_sel;

endmodule : spm_port

// *** verification/spm_port_checker.sv ***
`timescale 1ns/1ps
// ----------
// Port checker
// ----------
module spm_port_checker (
  input wire logic                      REF_CLK,
  input wire logic                      RST,
  input wire logic                      S_AXI_AWVALID,
  input wire logic                      S_AXI_AWREADY,
  input wire logic                      S_AXI_WVALID,
  input wire logic                      S_AXI_WREADY,
  input wire logic [1:0]                S_AXI_BRESP,
  input wire logic                      S_AXI_BVALID,
  input wire logic                      S_AXI_BREADY,
  input wire logic [19:0]               S_AXI_ARADDR,
  input wire logic                      S_AXI_ARVALID,
  input wire logic                      S_AXI_ARREADY,
  input wire logic [31:0]               S_AXI_RDATA,
  input wire logic                      S_AXI_RVALID,
  input wire logic                      S_AXI_RREADY,
  input wire spm_pkg::spm_pin_drive_t   PIN_DRIVE,
  input wire spm_pkg::spm_ser_from_t    SER_FROM,
  input wire logic [2:0]                SER_PIN_OWNED
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Read request taken and its register index
  wire logic        ar_go  = S_AXI_ARVALID && S_AXI_ARREADY;
  wire logic [17:0] ar_idx = S_AXI_ARADDR[19:2];

  resp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped early");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped early");
  read_latency_a: assert property (ar_go |=> S_AXI_RVALID)
    else $error("read answer late");
  write_latency_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |-> ##[1:2] S_AXI_BVALID) else $error("write answer late");
  dir_reads_ones_a: assert property (ar_go && ar_idx == spm_pkg::IDX_PORT_DIR |=> S_AXI_RDATA == 32'h000000ff)
    else $error("direction read not all ones");
  fsel_upper_zero_a: assert property (ar_go && ar_idx == spm_pkg::IDX_FUNC_SEL |=> S_AXI_RDATA[31:3] == 29'h0)
    else $error("select upper bits not zero");
  mode_fixed_a: assert property (ar_go && ar_idx == spm_pkg::IDX_TX_DRIVE
    |=> S_AXI_RDATA[7:3] == 5'h1f && !S_AXI_RDATA[1]) else $error("mode fixed bits wrong");
  reset_drive_a: assert property ($fell(RST) |-> PIN_DRIVE == '0 && SER_PIN_OWNED == 3'h0)
    else $error("pins not released by reset");
  upper_pullup_a: assert property ((PIN_DRIVE.pu[5:3] & PIN_DRIVE.oe[5:3]) == 3'h0)
    else $error("pull-up on a driven pin");
  si_input_a: assert property (SER_PIN_OWNED[1] && $past(SER_PIN_OWNED[1]) |-> !PIN_DRIVE.oe[1])
    else $error("serial input pin driven");
  // Open drain may release a high bit; a low bit is always driven low
  so_drive_a: assert property (SER_PIN_OWNED[2] && $past(SER_PIN_OWNED[2], 2) |-> ($past(SER_FROM.so_data) ?
    (!PIN_DRIVE.oe[2] || PIN_DRIVE.o[2]) : (PIN_DRIVE.oe[2] && !PIN_DRIVE.o[2]))) else $error("serial out wrong");
  sck_drive_a: assert property (SER_PIN_OWNED[0] && $past(SER_PIN_OWNED[0], 2) |->
    PIN_DRIVE.oe[0] == $past(SER_FROM.sck_oe) && (!PIN_DRIVE.oe[0] || PIN_DRIVE.o[0] == $past(SER_FROM.sck_out)))
    else $error("serial clock pin wrong");
endmodule : spm_port_checker

bind spm_port spm_port_checker u_chk (.REF_CLK(REF_CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .PIN_DRIVE(PIN_DRIVE), .SER_FROM(SER_FROM), .SER_PIN_OWNED(SER_PIN_OWNED));

// *** verification/spm_ser_model.sv ***
`timescale 1ns/1ps
// ----------
// Serial unit stand-in
// ----------
module spm_ser_model (
  input wire logic                 clk,
  input wire logic                 rst,
  output spm_pkg::spm_ser_from_t   ser_from
);
  logic [7:0] cnt_q;
  // Free counter; changes land just after each edge
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // Irregular data; clock direction swaps every 32 cycles to test both ways
  assign ser_from.so_data = cnt_q[0] ^ cnt_q[3] ^ cnt_q[6];
  assign ser_from.sck_out = cnt_q[1];
  assign ser_from.sck_oe  = cnt_q[5];
endmodule : spm_ser_model

// *** verification/six_bit_port_with_pin_mux_tb.sv ***
`timescale 1ns/1ps
module six_bit_port_with_pin_mux_tb;
  logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [19:0] awaddr = 20'h0, araddr = 20'h0;
  logic [31:0] wdata = 32'h0, rdata, rd_d;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, rsp;
  logic awready, wready, bvalid, arready, rvalid, si_data, sck_in, tx_sel, od;
  logic [5:0] pin_i, ext = 6'h00, dir, dat, pu, m, md;
  logic [7:0] v;
  logic [2:0] owned, fs;
  spm_pkg::spm_pin_drive_t drive;
  spm_pkg::spm_ser_from_t ser;
  int seed = 32'h6d35bd2a;
  int fail_count = 0;
  int samples_checked = 0;

  always #12.5 clk = ~clk;
  // Wire level: own drive first, else pull-up, else the outside world
  assign pin_i = (drive.oe & drive.o) | (~drive.oe & (drive.pu | ext));

  spm_port u_dut (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PIN_I(pin_i), .PIN_DRIVE(drive),
    .SER_FROM(ser), .SER_SI_DATA(si_data), .SER_SCK_IN(sck_in), .SER_PIN_OWNED(owned), .TX_ROUTE_SEL(tx_sel));
  spm_ser_model u_ser (.clk(clk), .rst(rst), .ser_from(ser));

  // ----------
  // Bus cycles and comparison
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Address and data offered together, each released once taken; handshakes are
  // judged at the falling edge, where the slave's outputs have settled, to dodge
  // the race with its own flops at the rising edge
  task automatic wr(input logic [17:0] idx, input logic [7:0] d, input logic [3:0] s);
    logic aw_ok, w_ok, b_ok;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {$random(seed)} << 8 | {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      aw_ok = awready;
      w_ok = wready;
      b_ok = (bvalid === 1'b1);
      rsp = bresp;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end while (!b_ok);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [17:0] idx);
    logic ar_ok, r_ok;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ar_ok = arready;
      r_ok = (rvalid === 1'b1);
      rd_d = rdata;
      rsp = rresp;
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
    end while (!r_ok);
    rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [17:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(rd_d, exp);
  endtask : rchk

  // Output pins give the stored bit, input pins the level
  function automatic logic [31:0] exp_port(input logic [5:0] dr, input logic [5:0] dt, input logic [5:0] lv);
    return {26'h0, (dr & dt) | (~dr & lv)};
  endfunction : exp_port

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // Whole run is under two thousand cycles, far below this limit
  initial begin
    #(25 * 40000);
    fail_count++;
    results();
  end

  // ----------
  // Scenarios
  // ----------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      rchk(spm_pkg::IDX_PORT_DATA, exp_port(6'h00, 6'h00, ext));
      rchk(spm_pkg::IDX_PORT_DIR, 32'hff);
      rchk(spm_pkg::IDX_PORT_PULLUP, 32'h0);
      rchk(spm_pkg::IDX_FUNC_SEL, 32'h0);
      rchk(spm_pkg::IDX_TX_DRIVE, 32'hf8);
      chk({31'h0, tx_sel}, 32'h0);
      for (int i = 0; i < 8; i++) begin
        v = (i == 0) ? 8'hff : 8'($random(seed));
        wr(spm_pkg::IDX_TX_DRIVE, v, 4'hf);
        rchk(spm_pkg::IDX_TX_DRIVE, {24'h0, 8'hf8 | (v & 8'h05)});
        chk({31'h0, tx_sel}, {31'h0, v[2]});
        wr(spm_pkg::IDX_FUNC_SEL, v, 4'hf);
        rchk(spm_pkg::IDX_FUNC_SEL, {29'h0, v[2:0]});
        chk({29'h0, owned}, {29'h0, v[2:0]});
      end
      for (int i = 0; i < 24; i++) begin
        dir = 6'($random(seed));
        dat = 6'($random(seed));
        pu = 6'($random(seed));
        fs = (i < 12) ? 3'h0 : 3'($random(seed));
        od = (i < 12) ? 1'b0 : i[0];
        ext <= 6'($random(seed));
        wr(spm_pkg::IDX_TX_DRIVE, {7'h0, od}, 4'hf);
        wr(spm_pkg::IDX_FUNC_SEL, {5'h0, fs}, 4'hf);
        wr(spm_pkg::IDX_PORT_DIR, {2'h0, dir}, 4'hf);
        wr(spm_pkg::IDX_PORT_DATA, {2'h0, dat}, 4'hf);
        wr(spm_pkg::IDX_PORT_PULLUP, {2'h0, pu}, 4'hf);
        chk({30'h0, rsp}, {30'h0, spm_pkg::RESP_OKAY});
        repeat (6) @(posedge clk);
        // Pins held by the serial unit are judged by the checker instead
        m = {3'h7, ~fs};
        md = m & ~{3'h0, od, 2'h0};
        rd(spm_pkg::IDX_PORT_DATA);
        chk({30'h0, rsp}, {30'h0, spm_pkg::RESP_OKAY});
        chk(rd_d & {26'h0, m}, exp_port(dir, dat, pu | ext) & {26'h0, m});
        // Serial side sees the filtered pin level: undriven input pin, or a quiet general pin
        if (fs[1]) begin
          chk({31'h0, si_data}, {31'h0, (~dir[1] & pu[1]) | ext[1]});
        end
        if (!fs[0]) begin
          chk({31'h0, sck_in}, {31'h0, dir[0] ? dat[0] : (pu[0] | ext[0])});
        end
        chk({26'h0, drive.oe & md}, {26'h0, dir & md});
        chk({26'h0, drive.o & dir & md}, {26'h0, dat & dir & md});
        chk({26'h0, drive.pu}, {26'h0, ~dir & pu});
      end
      // Disabled byte lane leaves the register alone
      wr(spm_pkg::IDX_PORT_PULLUP, 8'h3f, 4'he);
      rchk(spm_pkg::IDX_PORT_PULLUP, {26'h0, pu});
      rchk(18'h00001, 32'h0);
      chk({30'h0, rsp}, {30'h0, spm_pkg::RESP_SLVERR});
      wr(18'h00001, 8'hff, 4'hf);
      chk({30'h0, rsp}, {30'h0, spm_pkg::RESP_SLVERR});
      // Second reset in mid-run
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
    end
    results();
  end
endmodule : six_bit_port_with_pin_mux_tb
